// ==== verilog/timer16_ctrl.sv ====
// 16-bit timer with capture, compare, one-pulse, PWM and low-power handling
// Summary of operation
// RL1 - Timer keeps running during CPU wait
// RL2 - Halt freezes counter; resumes from held count
// RL3 - Capture edge in halt arms; wake captures
// RL4 - Five events; compares absent in PWM mode
// RL5 - Shared request needs flag, enable, unmasked CPU
// RL6 - Capture enable gates both capture flags
// RL7 - Compare enable gates both compare flags
// RL8 - Overflow enable gates overflow flag
// RL9 - Force two copies level two to pin
// RL10 - Force one copies level one to pin
// RL11 - Compare two match drives level two
// RL12 - Capture one edge polarity select
// RL13 - Compare one match drives level one
// RL14 - Pin one enable gates drive only
// RL15 - Pin two enable gates drive only
// RL16 - One-pulse mode triggered by capture one
// RL17 - PWM: compare one width, compare two period
// RL18 - Clock select: /4, /2, /8, external
// RL19 - Capture two edge polarity select
// RL20 - External clock edge polarity select
// RL21 - PWM wins when both modes set
// RL22 - One-pulse trigger loads fffc, fffd, flag
// RL23 - Flag clears after status read, low access
// RL24 - Control registers reset zero, read/write
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module timer16_ctrl
	import timer16_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire bus_req_t bus_req_i,
	output logic [7:0] rdata_o,
	input wire logic halt_i,
	input wire logic global_mask_i,
	input wire logic capture_input_one_i,
	input wire logic capture_input_two_i,
	input wire logic external_clock_input_i,
	output logic compare_output_one_o,
	output logic compare_output_one_oe_o,
	output logic compare_output_two_o,
	output logic compare_output_two_oe_o,
	output logic irq_o
);
	// Registered state
	ctl_one_t ctl_one_q; // First control register
	ctl_two_t ctl_two_q; // Second control register
	flags_t flags_q; // Event flags
	flags_t clr_armed_q; // Flags seen by a status read
	logic [15:0] cnt_q; // Free-running counter
	logic [15:0] cmp1_q; // Compare value one
	logic [15:0] cmp2_q; // Compare value two
	logic [15:0] cap1_q; // Capture value one
	logic [15:0] cap2_q; // Capture value two
	logic [1:0] cmp_hold_q; // Compare inhibited between high and low writes
	logic [2:0] div_q; // Prescaler
	logic [2:0] pin_m1_q, pin_m2_q, pin_m3_q; // Pin synchronisers
	logic [2:0] pin_s_q; // Filtered pin levels
	logic [2:0] pin_p_q; // Filtered levels one cycle back
	logic [1:0] halt_arm_q; // Capture edges seen during halt
	logic halt_q; // Halt input one cycle back
	logic out1_q, out2_q, oe1_q, oe2_q, irq_q;
	logic [7:0] rdata_q;
	// Combinational terms
	mode_t mode;
	logic run, tick, cap1_ev, cap2_ev, opm_trig, hit1, hit2, ovf, halt_exit, irq_pend;
	logic wr_cnt, clr_acc_ic1, clr_acc_oc1, clr_acc_cnt, clr_acc_ic2, clr_acc_oc2;
	logic [2:0] pin_s_d;
	flags_t set_f, clr_f;

	// Edge of a filtered level with selectable polarity
	function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
		edge_hit = rising ? (cur & ~prev) : (prev & ~cur);
	endfunction

	// Access of either kind to one register index
	function automatic logic touch(input bus_req_t r, input logic [3:0] a);
		touch = (r.wr | r.rd) & (r.addr == a);
	endfunction

	// PWM takes precedence so the two modes never fight over pin one
	always_comb begin
		if (ctl_two_q.pwm_enable) begin
			mode = MODE_PWM; // RL21
		end else if (ctl_two_q.one_pulse_enable) begin
			mode = MODE_OPM;
		end else begin
			mode = MODE_NORMAL;
		end
	end

	// Three-stage pin synchronisers; a level counts once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pin_m1_q <= 3'h0;
			pin_m2_q <= 3'h0;
			pin_m3_q <= 3'h0;
			pin_s_q <= 3'h0;
			pin_p_q <= 3'h0;
		end else if (clk_en_i) begin
			pin_m1_q <= {external_clock_input_i, capture_input_two_i, capture_input_one_i};
			pin_m2_q <= pin_m1_q;
			pin_m3_q <= pin_m2_q;
			pin_s_q <= pin_s_d;
			pin_p_q <= pin_s_q;
		end
	end

	// Only bits where stages two and three agree may move
	always_comb begin
		pin_s_d = (pin_m2_q & ~(pin_m2_q ^ pin_m3_q)) | (pin_s_q & (pin_m2_q ^ pin_m3_q));
	end

	// Prescaler terminal count per clock-select code
	function automatic logic [2:0] div_last(input logic [1:0] sel);
		case (sel)
			CLK_SEL_DIV2: div_last = DIV2_LAST;
			CLK_SEL_DIV8: div_last = DIV8_LAST;
			default: div_last = DIV4_LAST;
		endcase
	endfunction

	// Event decode; there is no wait input because wait changes nothing here
	always_comb begin
		run = clk_en_i & ~halt_i; // RL1 RL2
		halt_exit = clk_en_i & halt_q & ~halt_i;
		cap1_ev = edge_hit(pin_p_q[PIN_CAP1], pin_s_q[PIN_CAP1], ctl_one_q.capture_edge_one); // RL12
		cap2_ev = edge_hit(pin_p_q[PIN_CAP2], pin_s_q[PIN_CAP2], ctl_two_q.capture_edge_two); // RL19
		opm_trig = run & cap1_ev & (mode == MODE_OPM); // RL16
		if (ctl_two_q.clock_select_field == CLK_SEL_EXT) begin
			tick = run & edge_hit(pin_p_q[PIN_EXT], pin_s_q[PIN_EXT], ctl_two_q.ext_clock_edge); // RL20
		end else begin
			tick = run & (div_q == div_last(ctl_two_q.clock_select_field)); // RL18
		end
		hit1 = tick & ~cmp_hold_q[0] & (cnt_q == cmp1_q);
		hit2 = tick & ~cmp_hold_q[1] & (cnt_q == cmp2_q);
		ovf = tick & (cnt_q == CNT_TOP);
		wr_cnt = bus_req_i.wr & ((bus_req_i.addr == ADDR_CNT_LO) | (bus_req_i.addr == ADDR_ACNT_LO));
	end

	// Control registers; a new setting acts from the next mclk cycle
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctl_one_q <= ctl_one_t'(RST_CTL); // RL24
			ctl_two_q <= ctl_two_t'(RST_CTL); // RL24
		end else if (clk_en_i && bus_req_i.wr) begin
			if (bus_req_i.addr == ADDR_CTL_ONE) begin
				ctl_one_q <= ctl_one_t'(bus_req_i.wdata);
			end
			if (bus_req_i.addr == ADDR_CTL_TWO) begin
				ctl_two_q <= ctl_two_t'(bus_req_i.wdata);
			end
		end
	end

	// Compare values; high write inhibits compare until the low byte lands
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cmp1_q <= RST_CMP;
			cmp2_q <= RST_CMP;
			cmp_hold_q <= 2'h0;
		end else if (clk_en_i && bus_req_i.wr) begin
			case (bus_req_i.addr)
				ADDR_CMP1_HI: begin
					cmp1_q[15:8] <= bus_req_i.wdata;
					cmp_hold_q[0] <= 1'b1;
				end
				ADDR_CMP1_LO: begin
					cmp1_q[7:0] <= bus_req_i.wdata;
					cmp_hold_q[0] <= 1'b0;
				end
				ADDR_CMP2_HI: begin
					cmp2_q[15:8] <= bus_req_i.wdata;
					cmp_hold_q[1] <= 1'b1;
				end
				ADDR_CMP2_LO: begin
					cmp2_q[7:0] <= bus_req_i.wdata;
					cmp_hold_q[1] <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// Prescaler stops in halt along with everything it feeds
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			div_q <= 3'h0;
		end else if (run) begin
			div_q <= (div_q >= div_last(ctl_two_q.clock_select_field)) ? 3'h0 : div_q + 3'h1;
		end
	end

	// Counter: software write, one-pulse trigger and PWM period reload all restart at the reset value
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cnt_q <= CNT_RESET;
		end else if (clk_en_i) begin
			if (wr_cnt || opm_trig) begin
				cnt_q <= CNT_RESET; // RL22
			end else if (hit2 && mode == MODE_PWM) begin
				cnt_q <= CNT_RESET; // RL17
			end else if (tick) begin
				cnt_q <= cnt_q + 16'h0001; // RL2
			end
		end
	end

	// Halt tracking; edges during halt are remembered and captured on wake
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			halt_q <= 1'b0;
			halt_arm_q <= 2'h0;
		end else if (clk_en_i) begin
			halt_q <= halt_i;
			if (halt_exit) begin
				halt_arm_q <= 2'h0;
			end else if (halt_i) begin
				halt_arm_q <= halt_arm_q | {cap2_ev, cap1_ev & (mode == MODE_NORMAL)}; // RL3
			end
		end
	end

	// Capture registers
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cap1_q <= 16'h0000;
			cap2_q <= 16'h0000;
		end else if (clk_en_i) begin
			if (opm_trig) begin
				cap1_q <= OPM_CAPTURE; // RL22
			end else if ((run && cap1_ev && mode == MODE_NORMAL) || (halt_exit && halt_arm_q[0])) begin
				cap1_q <= cnt_q; // RL3
			end
			if ((run && cap2_ev) || (halt_exit && halt_arm_q[1])) begin
				cap2_q <= cnt_q; // RL3
			end
		end
	end

	// Flag set and clear terms; compare flags stay quiet in PWM, compare one also in one-pulse
	always_comb begin
		set_f.capture_flag_one = (run & cap1_ev & (mode != MODE_PWM)) | (halt_exit & halt_arm_q[0])
			| (hit2 & (mode == MODE_PWM)); // RL4
		set_f.capture_flag_two = (run & cap2_ev) | (halt_exit & halt_arm_q[1]);
		set_f.compare_flag_one = hit1 & (mode == MODE_NORMAL); // RL4
		set_f.compare_flag_two = hit2 & (mode != MODE_PWM); // RL4
		set_f.overflow_flag = ovf & ~(mode == MODE_PWM & hit2);
		clr_acc_ic1 = touch(bus_req_i, ADDR_CAP1_LO);
		clr_acc_oc1 = touch(bus_req_i, ADDR_CMP1_LO);
		clr_acc_cnt = touch(bus_req_i, ADDR_CNT_LO);
		clr_acc_ic2 = touch(bus_req_i, ADDR_CAP2_LO);
		clr_acc_oc2 = touch(bus_req_i, ADDR_CMP2_LO);
		clr_f = clr_armed_q & {clr_acc_ic1, clr_acc_oc1, clr_acc_cnt, clr_acc_ic2, clr_acc_oc2}; // RL23
	end

	// Flags: a set in the same cycle as a clear wins
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			flags_q <= flags_t'(5'h00);
			clr_armed_q <= flags_t'(5'h00);
		end else if (clk_en_i) begin
			flags_q <= (flags_q & ~clr_f) | set_f; // RL23
			if (bus_req_i.rd && bus_req_i.addr == ADDR_STATUS) begin
				clr_armed_q <= flags_q; // RL23
			end else begin
				clr_armed_q <= clr_armed_q & ~clr_f;
			end
		end
	end

	// Compare pins; forcing only acts in normal mode, enables gate just the pin drive
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			out1_q <= 1'b0;
			out2_q <= 1'b0;
			oe1_q <= 1'b0;
			oe2_q <= 1'b0;
		end else if (clk_en_i) begin
			oe1_q <= ctl_two_q.compare_pin_one_enable; // RL14
			oe2_q <= ctl_two_q.compare_pin_two_enable; // RL15
			case (mode)
				MODE_OPM: begin
					if (opm_trig) begin
						out1_q <= ctl_one_q.output_level_two; // RL22
					end else if (hit1) begin
						out1_q <= ctl_one_q.output_level_one; // RL16
					end
				end
				MODE_PWM: begin
					if (hit2) begin
						out1_q <= ctl_one_q.output_level_two; // RL11
					end else if (hit1) begin
						out1_q <= ctl_one_q.output_level_one; // RL17
					end
				end
				default: begin
					if (ctl_one_q.force_level_one || hit1) begin
						out1_q <= ctl_one_q.output_level_one; // RL10 RL13
					end
					if (ctl_one_q.force_level_two || hit2) begin
						out2_q <= ctl_one_q.output_level_two; // RL9 RL11
					end
				end
			endcase
		end
	end

	// Shared request; no flag sets during halt so it cannot end a halt
	always_comb begin
		irq_pend = (ctl_one_q.capture_irq_enable & (flags_q.capture_flag_one | flags_q.capture_flag_two)) // RL6
			| (ctl_one_q.compare_irq_enable & (flags_q.compare_flag_one | flags_q.compare_flag_two)) // RL7
			| (ctl_one_q.overflow_irq_enable & flags_q.overflow_flag); // RL8
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			irq_q <= 1'b0;
		end else if (clk_en_i) begin
			irq_q <= irq_pend & ~global_mask_i; // RL5 RL1
		end
	end

	// Read data one cycle after the strobe; unmapped index reads zero
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 8'h00;
		end else if (clk_en_i && bus_req_i.rd) begin
			case (bus_req_i.addr)
				ADDR_CTL_ONE: rdata_q <= ctl_one_q; // RL24
				ADDR_CTL_TWO: rdata_q <= ctl_two_q;
				ADDR_STATUS: rdata_q <= {flags_q, 3'h0};
				ADDR_CAP1_HI: rdata_q <= cap1_q[15:8];
				ADDR_CAP1_LO: rdata_q <= cap1_q[7:0];
				ADDR_CMP1_HI: rdata_q <= cmp1_q[15:8];
				ADDR_CMP1_LO: rdata_q <= cmp1_q[7:0];
				ADDR_CNT_HI, ADDR_ACNT_HI: rdata_q <= cnt_q[15:8];
				ADDR_CNT_LO, ADDR_ACNT_LO: rdata_q <= cnt_q[7:0];
				ADDR_CAP2_HI: rdata_q <= cap2_q[15:8];
				ADDR_CAP2_LO: rdata_q <= cap2_q[7:0];
				ADDR_CMP2_HI: rdata_q <= cmp2_q[15:8];
				ADDR_CMP2_LO: rdata_q <= cmp2_q[7:0];
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign rdata_o = rdata_q;
	assign compare_output_one_o = out1_q;
	assign compare_output_one_oe_o = oe1_q;
	assign compare_output_two_o = out2_q;
	assign compare_output_two_oe_o = oe2_q;
	assign irq_o = irq_q;

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	chk_irq_raise: assert property (clk_en_i && irq_pend && !global_mask_i |=> irq_o) // RL5
		else $error("request missing with enabled flag");
	chk_irq_masked: assert property (clk_en_i && global_mask_i |=> !irq_o) // RL5
		else $error("request while cpu mask set");
	chk_cap_gate: assert property (clk_en_i && !ctl_one_q.capture_irq_enable // RL6
		&& !flags_q.compare_flag_one && !flags_q.compare_flag_two && !flags_q.overflow_flag |=> !irq_o)
		else $error("capture request while disabled");
	chk_ovf_request: assert property (clk_en_i && !global_mask_i && ctl_one_q.overflow_irq_enable // RL8
		&& flags_q.overflow_flag |=> irq_o)
		else $error("overflow request missing");
	chk_halt_freeze: assert property (halt_i && !wr_cnt |=> $stable(cnt_q)) // RL2
		else $error("counter moved in halt");
	chk_force_one: assert property (clk_en_i && mode == MODE_NORMAL && ctl_one_q.force_level_one // RL10
		|=> out1_q == $past(ctl_one_q.output_level_one))
		else $error("forced level one not on pin");
	chk_opm_load: assert property (opm_trig |=> cnt_q == CNT_RESET && cap1_q == OPM_CAPTURE // RL22
		&& flags_q.capture_flag_one && out1_q == $past(ctl_one_q.output_level_two))
		else $error("one-pulse trigger load wrong");
	chk_pwm_wins: assert property (clk_en_i && ctl_two_q.pwm_enable && ctl_two_q.one_pulse_enable // RL21
		&& hit2 |=> cnt_q == CNT_RESET && flags_q.capture_flag_one)
		else $error("pwm not dominant");
	chk_rd_latency: assert property (clk_en_i && bus_req_i.rd && bus_req_i.addr == ADDR_CTL_ONE // RL24
		|=> rdata_o == $past(ctl_one_q))
		else $error("control read data wrong");
	chk_ovf_flag: assert property (ovf && mode == MODE_NORMAL |=> flags_q.overflow_flag) // RL4
		else $error("overflow flag not set");

	cov_opm_trig: cover property (opm_trig);
	cov_pwm_period: cover property (hit2 && mode == MODE_PWM);
	cov_halt_capture: cover property (halt_exit && halt_arm_q[0]);
	cov_irq: cover property (irq_o);
endmodule

// ==== verilog/timer16_pkg.sv ====
// Constants, register layouts and carrier types for the 16-bit timer control block
package timer16_pkg;
	// Register indices on the 4-bit register port
	localparam logic [3:0] ADDR_CTL_TWO = 4'h1;
	localparam logic [3:0] ADDR_CTL_ONE = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_CAP1_HI = 4'h4;
	localparam logic [3:0] ADDR_CAP1_LO = 4'h5;
	localparam logic [3:0] ADDR_CMP1_HI = 4'h6;
	localparam logic [3:0] ADDR_CMP1_LO = 4'h7;
	localparam logic [3:0] ADDR_CNT_HI = 4'h8;
	localparam logic [3:0] ADDR_CNT_LO = 4'h9;
	localparam logic [3:0] ADDR_ACNT_HI = 4'ha;
	localparam logic [3:0] ADDR_ACNT_LO = 4'hb;
	localparam logic [3:0] ADDR_CAP2_HI = 4'hc;
	localparam logic [3:0] ADDR_CAP2_LO = 4'hd;
	localparam logic [3:0] ADDR_CMP2_HI = 4'he;
	localparam logic [3:0] ADDR_CMP2_LO = 4'hf;
	// Reset and load values
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [15:0] RST_CMP = 16'h8000;
	localparam logic [15:0] CNT_RESET = 16'hfffc;
	localparam logic [15:0] OPM_CAPTURE = 16'hfffd;
	localparam logic [15:0] CNT_TOP = 16'hffff;
	// Clock-select encodings
	localparam logic [1:0] CLK_SEL_DIV4 = 2'b00;
	localparam logic [1:0] CLK_SEL_DIV2 = 2'b01;
	localparam logic [1:0] CLK_SEL_DIV8 = 2'b10;
	localparam logic [1:0] CLK_SEL_EXT = 2'b11;
	// Prescaler terminal counts (ratio minus one)
	localparam logic [2:0] DIV2_LAST = 3'h1;
	localparam logic [2:0] DIV4_LAST = 3'h3;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	// Synchronised pin positions
	localparam int PIN_CAP1 = 0;
	localparam int PIN_CAP2 = 1;
	localparam int PIN_EXT = 2;
	// First control register layout, bit 7 first
	typedef struct packed {
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic force_level_two;
		logic force_level_one;
		logic output_level_two;
		logic capture_edge_one;
		logic output_level_one;
	} ctl_one_t;
	// Second control register layout, bit 7 first
	typedef struct packed {
		logic compare_pin_one_enable;
		logic compare_pin_two_enable;
		logic one_pulse_enable;
		logic pwm_enable;
		logic [1:0] clock_select_field;
		logic capture_edge_two;
		logic ext_clock_edge;
	} ctl_two_t;
	// Event flags, in status bit order 7 down to 3
	typedef struct packed {
		logic capture_flag_one;
		logic compare_flag_one;
		logic overflow_flag;
		logic capture_flag_two;
		logic compare_flag_two;
	} flags_t;
	// One register-port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
	// Operating mode
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_OPM = 2'b01,
		MODE_PWM = 2'b10
	} mode_t;
endpackage

// ==== tb/timer16_pins.sv ====
// Far-side model of the timer pins: capture inputs, external clock and the compare pin wires
`timescale 1ns/1ps
module timer16_pins (
	input wire logic mclk_i,
	input wire logic cmp_one_i,
	input wire logic cmp_one_oe_i,
	input wire logic cmp_two_i,
	input wire logic cmp_two_oe_i,
	output logic cap_one_o,
	output logic cap_two_o,
	output logic ext_clk_o,
	output logic pin_one_o,
	output logic pin_two_o
);
	// Pattern on a released pin; no pull-up, so a stale level must not look valid
	logic wobble_q;
	initial begin
		cap_one_o = 1'b0;
		cap_two_o = 1'b0;
		ext_clk_o = 1'b0;
		wobble_q = 1'b0;
	end
	// Changes every cycle so an undriven pin never passes for a driven level
	always @(posedge mclk_i) begin
		wobble_q <= ~wobble_q;
	end
	// Wire level seen at the board
	assign pin_one_o = cmp_one_oe_i ? cmp_one_i : wobble_q;
	assign pin_two_o = cmp_two_oe_i ? cmp_two_i : wobble_q;
	// Set one capture pin, then hold it well past the synchroniser delay
	task automatic set_cap(input int ch, input logic lvl);
		@(posedge mclk_i);
		if (ch == 1) begin
			cap_one_o <= lvl;
		end else begin
			cap_two_o <= lvl;
		end
		repeat (8) @(posedge mclk_i);
	endtask
	// Toggle the external clock n times, slow against mclk; it stands still afterwards
	task automatic ext_burst(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			ext_clk_o <= ~ext_clk_o;
			repeat (7) @(posedge mclk_i);
		end
	endtask
endmodule

// ==== tb/timer16_control_and_modes_bench.sv ====
// Self-checking bench for the timer control, compare, capture, mode and halt behaviour
`timescale 1ns/1ps
module timer16_control_and_modes_bench
	import timer16_pkg::*;
;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic halt_i = 1'b0;
	logic global_mask_i = 1'b1;
	bus_req_t bus_req_i = '0;
	logic [7:0] rdata_o;
	logic cap_one, cap_two, ext_clk, out_one, oe_one, out_two, oe_two, irq_o, pin_one, pin_two;
	int num_errors = 0;
	int checks = 0;
	int hi_n;
	int lo_n;
	logic [7:0] d, a, b;
	// Low-byte indices that finish a flag clear
	logic [3:0] low_a [5] = '{ADDR_CAP1_LO, ADDR_CMP1_LO, ADDR_CNT_LO, ADDR_CAP2_LO, ADDR_CMP2_LO};
	logic [1:0] sel_a [3] = '{CLK_SEL_DIV4, CLK_SEL_DIV2, CLK_SEL_DIV8};
	// Counter steps in 64 mclk cycles for /4, /2, /8
	logic [7:0] step_a [3] = '{8'h10, 8'h20, 8'h08};

	// 100 MHz clock
	always #5 mclk_i = ~mclk_i;

	timer16_ctrl uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .bus_req_i(bus_req_i),
		.rdata_o(rdata_o), .halt_i(halt_i), .global_mask_i(global_mask_i), .capture_input_one_i(cap_one),
		.capture_input_two_i(cap_two), .external_clock_input_i(ext_clk), .compare_output_one_o(out_one),
		.compare_output_one_oe_o(oe_one), .compare_output_two_o(out_two), .compare_output_two_oe_o(oe_two),
		.irq_o(irq_o));
	timer16_pins pins (.mclk_i(mclk_i), .cmp_one_i(out_one), .cmp_one_oe_i(oe_one), .cmp_two_i(out_two),
		.cmp_two_oe_i(oe_two), .cap_one_o(cap_one), .cap_two_o(cap_two), .ext_clk_o(ext_clk),
		.pin_one_o(pin_one), .pin_two_o(pin_two));

	// Single exit point with the verdict
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			num_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
		@(posedge mclk_i);
		bus_req_i <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus_req_i <= '0;
	endtask
	// Read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [3:0] ad, output logic [7:0] rv);
		@(posedge mclk_i);
		bus_req_i <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus_req_i <= '0;
		#1 rv = rdata_o;
	endtask
	// High byte first, since that order re-enables the compare on the low byte
	task automatic wr16(input logic [3:0] hi_ad, input logic [15:0] v);
		wr(hi_ad, v[15:8]);
		wr(hi_ad + 4'h1, v[7:0]);
	endtask
	task automatic exp_rd(input logic [3:0] ad, input logic [7:0] m, input logic [7:0] want);
		logic [7:0] rv;
		rd(ad, rv);
		check(rv & m, want);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// Status read arms every set flag, the low-byte accesses then clear them
	task automatic clear_all();
		logic [7:0] rv;
		rd(ADDR_STATUS, rv);
		foreach (low_a[i]) rd(low_a[i], rv);
	endtask
	task automatic wait_st(input logic [7:0] m);
		logic [7:0] rv;
		rv = 8'h00;
		for (int n = 0; (rv & m) !== m; n++) begin
			if (n > 300) begin
				num_errors++;
				$display("BAD %0t status wait", $time);
				end_sim();
			end
			rd(ADDR_STATUS, rv);
		end
	endtask
	task automatic wait_pin(input logic v, input int lim);
		for (int n = 0; pin_one !== v; n++) begin
			if (n > lim) begin
				num_errors++;
				$display("BAD %0t pin wait", $time);
				end_sim();
			end
			settle(1);
		end
	endtask
	// Two counter samples exactly gap cycles apart
	task automatic cnt_gap(input int gap, output logic [7:0] delta);
		logic [7:0] c0, c1;
		rd(ADDR_CNT_LO, c0);
		repeat (gap - 2) @(posedge mclk_i);
		rd(ADDR_CNT_LO, c1);
		delta = c1 - c0;
	endtask

	// Hang guard
	initial begin
		#500us;
		num_errors++;
		$display("BAD %0t run timeout", $time);
		end_sim();
	end

	initial begin
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		// Reset values; status first, before the first overflow
		exp_rd(ADDR_STATUS, 8'hff, 8'h00);
		exp_rd(ADDR_CTL_ONE, 8'hff, RST_CTL);
		exp_rd(ADDR_CTL_TWO, 8'hff, RST_CTL);
		check({7'h0, irq_o}, 8'h00);
		// Read/write, and a strobe ignored while the clock enable is low
		wr(ADDR_CTL_ONE, 8'h5a);
		exp_rd(ADDR_CTL_ONE, 8'hff, 8'h5a);
		@(posedge mclk_i) clk_en_i <= 1'b0;
		wr(ADDR_CTL_ONE, 8'ha5);
		clk_en_i <= 1'b1;
		exp_rd(ADDR_CTL_ONE, 8'hff, 8'h5a);
		wr(ADDR_CTL_TWO, 8'h3c);
		exp_rd(ADDR_CTL_TWO, 8'hff, 8'h3c);
		wr(ADDR_CTL_TWO, 8'h00);
		wr(ADDR_CTL_ONE, 8'h00);
		// Overflow: enable, global mask, clear order
		wait_st(8'h20);
		check({7'h0, irq_o}, 8'h00);
		wr(ADDR_CTL_ONE, 8'h20);
		settle(4);
		check({7'h0, irq_o}, 8'h00);
		@(posedge mclk_i) global_mask_i <= 1'b0;
		settle(4);
		check({7'h0, irq_o}, 8'h01);
		rd(ADDR_STATUS, d);
		rd(ADDR_ACNT_LO, d);
		exp_rd(ADDR_STATUS, 8'h20, 8'h20);
		rd(ADDR_CNT_LO, d);
		exp_rd(ADDR_STATUS, 8'h20, 8'h00);
		settle(2);
		check({7'h0, irq_o}, 8'h00);
		// Prescaler ratios, then both external edges
		wr(ADDR_CTL_ONE, 8'h00);
		foreach (sel_a[i]) begin
			wr(ADDR_CTL_TWO, {4'h0, sel_a[i], 2'b00});
			settle(20);
			cnt_gap(64, d);
			check(d, step_a[i]);
		end
		wr(ADDR_CTL_TWO, 8'h0d);
		rd(ADDR_CNT_LO, a);
		pins.ext_burst(3);
		settle(8);
		rd(ADDR_CNT_LO, b);
		check(b - a, 8'h02);
		wr(ADDR_CTL_TWO, 8'h0c);
		rd(ADDR_CNT_LO, a);
		pins.ext_burst(3);
		settle(8);
		rd(ADDR_CNT_LO, b);
		check(b - a, 8'h02);
		// Compare matches, pin one enabled and pin two not
		wr(ADDR_CTL_TWO, 8'h84);
		clear_all();
		wr16(ADDR_CMP1_HI, 16'h0010);
		wr16(ADDR_CMP2_HI, 16'h0020);
		wr(ADDR_CTL_ONE, 8'h45);
		wr(ADDR_CNT_LO, 8'h00);
		wait_st(8'h48);
		check({6'h0, pin_one, oe_one}, 8'h03);
		check({7'h0, out_two}, 8'h01);
		check({7'h0, oe_two}, 8'h00);
		check({7'h0, irq_o}, 8'h01);
		wr(ADDR_CTL_ONE, 8'h01);
		settle(3);
		check({7'h0, irq_o}, 8'h00);
		// Forced levels on both pins
		wr(ADDR_CTL_TWO, 8'hc4);
		wr(ADDR_CTL_ONE, 8'h18);
		settle(3);
		check({6'h0, pin_one, pin_two}, 8'h00);
		wr(ADDR_CTL_ONE, 8'h1d);
		settle(3);
		check({6'h0, pin_one, pin_two}, 8'h03);
		wr(ADDR_CTL_TWO, 8'h04);
		settle(3);
		check({6'h0, oe_one, oe_two}, 8'h00);
		// Capture edges: rising on channel one, falling on channel two
		clear_all();
		wr(ADDR_CTL_ONE, 8'h82);
		pins.set_cap(1, 1'b1);
		wait_st(8'h80);
		settle(2);
		check({7'h0, irq_o}, 8'h01);
		rd(ADDR_CAP1_LO, d);
		pins.set_cap(1, 1'b0);
		exp_rd(ADDR_STATUS, 8'h90, 8'h00);
		pins.set_cap(2, 1'b1);
		exp_rd(ADDR_STATUS, 8'h90, 8'h00);
		pins.set_cap(2, 1'b0);
		exp_rd(ADDR_STATUS, 8'h90, 8'h10);
		clear_all();
		wr(ADDR_CTL_ONE, 8'h00);
		// Halt: counter frozen, capture armed and taken at exit
		wr(ADDR_CTL_TWO, 8'h06);
		@(posedge mclk_i) halt_i <= 1'b1;
		settle(4);
		rd(ADDR_CNT_LO, a);
		pins.set_cap(2, 1'b1);
		rd(ADDR_CNT_LO, b);
		check(b, a);
		exp_rd(ADDR_STATUS, 8'h10, 8'h00);
		@(posedge mclk_i) halt_i <= 1'b0;
		settle(10);
		exp_rd(ADDR_STATUS, 8'h10, 8'h10);
		exp_rd(ADDR_CAP2_LO, 8'hff, a);
		// Both mode bits: PWM must win
		clear_all();
		wr16(ADDR_CMP1_HI, 16'h0004);
		wr16(ADDR_CMP2_HI, 16'h0010);
		wr(ADDR_CTL_ONE, 8'h04);
		wr(ADDR_CTL_TWO, 8'hb4);
		// Restart from the reset value so the short period is reached at once
		wr(ADDR_CNT_LO, 8'h00);
		settle(20);
		hi_n = 0;
		lo_n = 0;
		repeat (200) begin
			settle(1);
			hi_n += (pin_one === 1'b1);
			lo_n += (pin_one === 1'b0);
		end
		check({7'h0, hi_n > 0 && lo_n > 0}, 8'h01);
		exp_rd(ADDR_STATUS, 8'hc8, 8'h80);
		// One pulse triggered by a rising capture edge
		wr(ADDR_CTL_TWO, 8'ha4);
		wr16(ADDR_CMP1_HI, 16'h0040);
		wr(ADDR_CTL_ONE, 8'h06);
		clear_all();
		pins.set_cap(1, 1'b1);
		check({7'h0, pin_one}, 8'h01);
		exp_rd(ADDR_CAP1_HI, 8'hff, OPM_CAPTURE[15:8]);
		exp_rd(ADDR_CAP1_LO, 8'hff, OPM_CAPTURE[7:0]);
		exp_rd(ADDR_STATUS, 8'h80, 8'h80);
		wait_pin(1'b0, 400);
		check({7'h0, pin_one}, 8'h00);
		end_sim();
	end
endmodule
